// ===== inc/loopb_regs_defs.svh
// Register offsets, field positions, reset values and selector codes
`ifndef LOOPB_REGS_DEFS_SVH
`define LOOPB_REGS_DEFS_SVH

// ==========================================================
// Word indices on HADDR[10:2] (printed offsets that are not word multiples)
`define IDX_PUMP_CTRL     9'h169
`define IDX_LOCK_CNT_HI   9'h16a
`define IDX_LOCK_CNT_LO   9'h16b
`define IDX_FILTER_RES    9'h16c
`define IDX_FILTER_CAP    9'h16d
`define IDX_STATUS_PIN2   9'h16e
`define IDX_FIXED_ONE     9'h171
`define IDX_FIXED_TWO     9'h172
`define IDX_POWER_DOWN    9'h173
`define IDX_OPTIMIZE_ONE  9'h17c
`define IDX_OPTIMIZE_TWO  9'h17d
`define IDX_LOOP_A_STAT   9'h182
`define IDX_LOOP_B_STAT   9'h183
`define IDX_INPUT_RB      9'h184
`define IDX_FEEDBACK_LO   9'h168
`define IDX_CAL_CTRL      9'h166
`define IDX_PIN1_SEL      9'h15f
`define ADDR_LSB          2

// ==========================================================
// Reset values
`define RST_PUMP_CTRL     8'h59
`define RST_LOCK_CNT_HI   8'h20
`define RST_LOCK_CNT_LO   8'h00
`define RST_FILTER_RES    8'h00
`define RST_FILTER_CAP    8'h00
`define RST_STATUS_PIN2   8'h16
`define RST_FIXED_ONE     8'h0a
`define RST_FIXED_TWO     8'h00
`define RST_POWER_DOWN    8'h00
`define RST_OPTIMIZE      8'h00
`define RST_LOOP_STAT     8'h00
`define RST_CAL_CTRL      8'h00
`define RST_PIN1_SEL      8'h0e

// ==========================================================
// Field positions
`define WND_HI            6
`define WND_LO            5
`define GAIN_HI           4
`define GAIN_LO           3
`define POL_BIT           2
`define HIZ_BIT           1
`define ALIGN_EN_BIT      6
`define CNT_HI_HI         5
`define RES4_HI           5
`define RES4_LO           3
`define RES3_HI           2
`define RES3_LO           0
`define CAP4_HI           7
`define CAP4_LO           4
`define CAP3_HI           3
`define CAP3_LO           0
`define PIN_SEL_HI        7
`define PIN_SEL_LO        3
`define PIN_DRV_HI        2
`define PIN_DRV_LO        0
`define PRE_OFF_BIT       6
`define PWR_OFF_BIT       5
`define LOST_BIT          2
`define LEVEL_BIT         1
`define CLEAR_BIT         0
`define CAL_DIS_BIT       2
`define SEL_LOOP_B        5'h02
`define SEL_BOTH          5'h03
`define CNT_W             14

`endif

// ===== inc/loopb_regs_pkg.sv
// Types shared by the loop-b register bank
package loopb_regs_pkg;

  typedef struct packed {
    logic [1:0] lock_window;
    logic [1:0] pump_gain;
    logic       pump_polarity;
    logic       pump_hiz;
    logic       align_request_enable;
    logic [2:0] filter_res_four_sel;
    logic [2:0] filter_res_three_sel;
    logic [3:0] filter_cap_four_sel;
    logic [3:0] filter_cap_three_sel;
    logic [4:0] status_pin_two_select;
    logic [2:0] status_pin_two_drive;
    logic       prescaler_off;
    logic       power_off;
  } analog_ctrl_type;

  typedef struct packed {
    logic [9:0] tuning_dac;
    logic [2:0] ref_selected;
  } input_status_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_COUNT = 3'b010,
    ST_LOCK  = 3'b100
  } lock_state_type;

endpackage : loopb_regs_pkg

// ===== logic/lock_lost_flag.sv
// Sticky lock-lost flag with hold-clear control for one loop
`timescale 1ns/1ps
`include "loopb_regs_defs.svh"

module lock_lost_flag (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Lock level and control
  input  wire logic lock_level,
  input  wire logic clear_hold,
  // Flag
  output logic      lost_flag
);

  logic level_d_r;
  logic lost_r;
  logic lost_nxt;
  wire  fall = level_d_r & ~lock_level;

  // A low level after the clear releases gives no edge, so no set
  assign lost_nxt = clear_hold ? 1'b0 : (lost_r | fall);
  assign lost_flag = lost_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_d_r <= 1'b0;
      lost_r    <= 1'b0;
    end else if (ce) begin
      level_d_r <= lock_level;
      lost_r    <= lost_nxt;
    end
  end

endmodule : lock_lost_flag

// ===== logic/lock_detector.sv
// Digital lock detect counter for the second loop
`timescale 1ns/1ps
`include "loopb_regs_defs.svh"

module lock_detector (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // Phase detector events
  input  wire logic                 pd_event,
  input  wire logic                 in_window,
  input  wire logic [`CNT_W-1:0]    lock_count,
  input  wire logic                 disable_loop,
  // Result
  output logic                      locked
);

  loopb_regs_pkg::lock_state_type state_r;
  loopb_regs_pkg::lock_state_type state_nxt;
  logic [`CNT_W-1:0] cnt_r;
  logic [`CNT_W-1:0] cnt_nxt;
  // Zero is invalid; treat as one so the detector cannot lock for free
  wire  [`CNT_W-1:0] target = (lock_count == '0) ? `CNT_W'(1) : lock_count;
  wire               hit = (cnt_r + `CNT_W'(1)) >= target;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      loopb_regs_pkg::ST_IDLE: begin
        cnt_nxt = '0;
        if (pd_event && in_window) begin
          state_nxt = hit ? loopb_regs_pkg::ST_LOCK
                          : loopb_regs_pkg::ST_COUNT;
          cnt_nxt   = `CNT_W'(1);
        end
      end
      loopb_regs_pkg::ST_COUNT: begin
        if (pd_event && !in_window) begin
          state_nxt = loopb_regs_pkg::ST_IDLE;
          cnt_nxt   = '0;
        end else if (pd_event) begin
          cnt_nxt = cnt_r + `CNT_W'(1);
          if (hit) state_nxt = loopb_regs_pkg::ST_LOCK;
        end
      end
      loopb_regs_pkg::ST_LOCK: begin
        if (pd_event && !in_window) begin
          state_nxt = loopb_regs_pkg::ST_IDLE;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = loopb_regs_pkg::ST_IDLE;
        cnt_nxt   = '0;
      end
    endcase
    if (disable_loop) begin
      state_nxt = loopb_regs_pkg::ST_IDLE;
      cnt_nxt   = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= loopb_regs_pkg::ST_IDLE;
      cnt_r   <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  assign locked = (state_r == loopb_regs_pkg::ST_LOCK);

endmodule : lock_detector

// ===== logic/loopb_regs.sv
// Second-loop configuration and status register bank on AHB-Lite
//
// Overview of operation
// - Lock window field, code 2 resets, 3.7 ns
// - Lock asserts after programmed count in window
// - Pump gain codes select four currents, reset 3
// - Polarity bit: 0 negative, 1 positive slope
// - Tri-state bit puts pump output high-Z
// - Align enable lets request pin pulse continuously
// - Fourth resistor select, codes 5-7 reserved
// - Third resistor select, reset 0, 5-7 reserved
// - Fourth capacitor select, codes 14-15 reserved
// - Third capacitor select, codes 14-15 reserved
// - Status pin two selector, reset second lock
// - Status pin two drive type, reset open drain
// - Power bits disable prescaler and whole loop
// - Lost flag sets on falling lock detect
// - Clear bit holds flag low until released
// - Bit 1 returns live lock detect level
// - Readback bits show selected reference input
// - Readback top bits give tuning DAC MSBs
// - Feedback low byte write starts calibration
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "loopb_regs_defs.svh"

module loopb_regs (
  // Clock, reset, enable
  input  wire logic                          CLK,
  input  wire logic                          RESETN,
  input  wire logic                          CE,
  // AHB-Lite slave
  input  wire logic                          HSEL,
  input  wire logic [11:0]                   HADDR,
  input  wire logic [1:0]                    HTRANS,
  input  wire logic                          HWRITE,
  input  wire logic [2:0]                    HSIZE,
  input  wire logic [31:0]                   HWDATA,
  input  wire logic                          HREADY,
  output logic      [31:0]                   HRDATA,
  output logic                               HREADYOUT,
  output logic                               HRESP,
  // Loop status inputs from the surrounding device
  input  wire logic                          LOOP_A_LOCK,
  input  wire logic                          PD_EVENT,
  input  wire logic                          PD_IN_WINDOW,
  input  wire loopb_regs_pkg::input_status_type INPUT_STATUS,
  input  wire logic                          ALIGN_PULSE,
  input  wire logic [18:0]                   PIN_SOURCES,
  // Controls to the analog loop
  output loopb_regs_pkg::analog_ctrl_type    ANALOG_CTRL,
  output logic                               LOOP_B_LOCK,
  output logic                               CAL_START,
  output logic                               ALIGN_REQUEST,
  output logic                               STATUS_PIN_TWO_O,
  output logic                               STATUS_PIN_TWO_OE
);

  // ========================================================
  // Reset release
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  wire rst_n = rst_sync_r;

  // ========================================================
  // Registers
  logic [7:0] pump_r;
  logic [7:0] cnt_hi_r;
  logic [7:0] cnt_lo_r;
  logic [7:0] res_r;
  logic [7:0] cap_r;
  logic [7:0] pin2_r;
  logic [7:0] fix1_r;
  logic [7:0] fix2_r;
  logic [7:0] pwr_r;
  logic [7:0] opt1_r;
  logic [7:0] opt2_r;
  logic       clr_a_r;
  logic       clr_b_r;
  logic [7:0] cal_r;
  logic [7:0] pin1_r;

  // ========================================================
  // Bus address and data phases
  logic       wr_pend_r;
  logic [8:0] wr_idx_r;
  logic [7:0] rd_data_r;

  function automatic logic [8:0] word_index(input logic [11:0] a);
    word_index = a[10:`ADDR_LSB];
  endfunction : word_index

  function automatic logic hit_at(input logic [8:0] idx,
                                  input logic [8:0] reg_idx);
    hit_at = (idx == reg_idx);
  endfunction : hit_at

  wire       a_phase = HSEL & HREADY & HTRANS[1];
  wire       a_write = a_phase & HWRITE;
  wire       a_read  = a_phase & ~HWRITE;
  wire [8:0] a_idx   = word_index(HADDR);
  wire [7:0] wd      = HWDATA[7:0];

  wire we_pump = wr_pend_r & hit_at(wr_idx_r, `IDX_PUMP_CTRL);
  wire we_chi  = wr_pend_r & hit_at(wr_idx_r, `IDX_LOCK_CNT_HI);
  wire we_clo  = wr_pend_r & hit_at(wr_idx_r, `IDX_LOCK_CNT_LO);
  wire we_res  = wr_pend_r & hit_at(wr_idx_r, `IDX_FILTER_RES);
  wire we_cap  = wr_pend_r & hit_at(wr_idx_r, `IDX_FILTER_CAP);
  wire we_pin2 = wr_pend_r & hit_at(wr_idx_r, `IDX_STATUS_PIN2);
  wire we_fix1 = wr_pend_r & hit_at(wr_idx_r, `IDX_FIXED_ONE);
  wire we_fix2 = wr_pend_r & hit_at(wr_idx_r, `IDX_FIXED_TWO);
  wire we_pwr  = wr_pend_r & hit_at(wr_idx_r, `IDX_POWER_DOWN);
  wire we_opt1 = wr_pend_r & hit_at(wr_idx_r, `IDX_OPTIMIZE_ONE);
  wire we_opt2 = wr_pend_r & hit_at(wr_idx_r, `IDX_OPTIMIZE_TWO);
  wire we_sta  = wr_pend_r & hit_at(wr_idx_r, `IDX_LOOP_A_STAT);
  wire we_stb  = wr_pend_r & hit_at(wr_idx_r, `IDX_LOOP_B_STAT);
  wire we_cal  = wr_pend_r & hit_at(wr_idx_r, `IDX_CAL_CTRL);
  wire we_pin1 = wr_pend_r & hit_at(wr_idx_r, `IDX_PIN1_SEL);
  wire we_fbl  = wr_pend_r & hit_at(wr_idx_r, `IDX_FEEDBACK_LO);

  // ========================================================
  // Lock detect and lost flags
  logic lock_b;
  logic lost_a;
  logic lost_b;

  lock_detector u_lock (
    .clk          (CLK),
    .rst_n        (rst_n),
    .ce           (CE),
    .pd_event     (PD_EVENT),
    .in_window    (PD_IN_WINDOW),
    .lock_count   ({cnt_hi_r[`CNT_HI_HI:0], cnt_lo_r}),
    .disable_loop (pwr_r[`PWR_OFF_BIT]),
    .locked       (lock_b)
  );

  lock_lost_flag u_lost_a (
    .clk        (CLK),
    .rst_n      (rst_n),
    .ce         (CE),
    .lock_level (LOOP_A_LOCK),
    .clear_hold (clr_a_r),
    .lost_flag  (lost_a)
  );

  lock_lost_flag u_lost_b (
    .clk        (CLK),
    .rst_n      (rst_n),
    .ce         (CE),
    .lock_level (lock_b),
    .clear_hold (clr_b_r),
    .lost_flag  (lost_b)
  );

  // ========================================================
  // Read decode
  // Loop-b level reads the detector output directly, whatever pin two routes
  wire [7:0] stat_a = {5'h00, lost_a, LOOP_A_LOCK, clr_a_r};
  wire [7:0] stat_b = {5'h00, lost_b, lock_b, clr_b_r};
  wire [7:0] in_rb  = {INPUT_STATUS.tuning_dac[9:8],
                       INPUT_STATUS.ref_selected, 3'h0};

  logic [7:0] rd_sel;

  always_comb begin
    unique case (1'b1)
      hit_at(a_idx, `IDX_PUMP_CTRL):    rd_sel = pump_r;
      hit_at(a_idx, `IDX_LOCK_CNT_HI):  rd_sel = cnt_hi_r;
      hit_at(a_idx, `IDX_LOCK_CNT_LO):  rd_sel = cnt_lo_r;
      hit_at(a_idx, `IDX_FILTER_RES):   rd_sel = res_r;
      hit_at(a_idx, `IDX_FILTER_CAP):   rd_sel = cap_r;
      hit_at(a_idx, `IDX_STATUS_PIN2):  rd_sel = pin2_r;
      hit_at(a_idx, `IDX_FIXED_ONE):    rd_sel = fix1_r;
      hit_at(a_idx, `IDX_FIXED_TWO):    rd_sel = fix2_r;
      hit_at(a_idx, `IDX_POWER_DOWN):   rd_sel = pwr_r;
      hit_at(a_idx, `IDX_OPTIMIZE_ONE): rd_sel = opt1_r;
      hit_at(a_idx, `IDX_OPTIMIZE_TWO): rd_sel = opt2_r;
      hit_at(a_idx, `IDX_LOOP_A_STAT):  rd_sel = stat_a;
      hit_at(a_idx, `IDX_LOOP_B_STAT):  rd_sel = stat_b;
      hit_at(a_idx, `IDX_INPUT_RB):     rd_sel = in_rb;
      hit_at(a_idx, `IDX_CAL_CTRL):     rd_sel = cal_r;
      hit_at(a_idx, `IDX_PIN1_SEL):     rd_sel = pin1_r;
      default:                          rd_sel = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 9'h000;
      rd_data_r <= 8'h00;
    end else if (CE) begin
      wr_pend_r <= a_write;
      wr_idx_r  <= a_idx;
      if (a_read) rd_data_r <= rd_sel;
    end
  end

  // ========================================================
  // Writable registers
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      pump_r   <= `RST_PUMP_CTRL;
      cnt_hi_r <= `RST_LOCK_CNT_HI;
      cnt_lo_r <= `RST_LOCK_CNT_LO;
      res_r    <= `RST_FILTER_RES;
      cap_r    <= `RST_FILTER_CAP;
      pin2_r   <= `RST_STATUS_PIN2;
      fix1_r   <= `RST_FIXED_ONE;
      fix2_r   <= `RST_FIXED_TWO;
      pwr_r    <= `RST_POWER_DOWN;
      opt1_r   <= `RST_OPTIMIZE;
      opt2_r   <= `RST_OPTIMIZE;
      clr_a_r  <= 1'b0;
      clr_b_r  <= 1'b0;
      cal_r    <= `RST_CAL_CTRL;
      pin1_r   <= `RST_PIN1_SEL;
    end else if (CE) begin
      // Bit 7 reserved, bit 0 kept as written for readback
      if (we_pump) pump_r   <= {1'b0, wd[6:0]};
      if (we_chi)  cnt_hi_r <= {1'b0, wd[6:0]};
      if (we_clo)  cnt_lo_r <= wd;
      if (we_res)  res_r    <= {2'b00, wd[5:0]};
      if (we_cap)  cap_r    <= wd;
      if (we_pin2) pin2_r   <= wd;
      if (we_fix1) fix1_r   <= wd;
      if (we_fix2) fix2_r   <= wd;
      if (we_pwr)  pwr_r    <= {1'b0, wd[6:5], 5'h00};
      if (we_opt1) opt1_r   <= wd;
      if (we_opt2) opt2_r   <= wd;
      if (we_sta)  clr_a_r  <= wd[`CLEAR_BIT];
      if (we_stb)  clr_b_r  <= wd[`CLEAR_BIT];
      if (we_cal)  cal_r    <= {5'h00, wd[2:0]};
      if (we_pin1) pin1_r   <= wd;
    end
  end

  // ========================================================
  // Outputs
  wire [4:0] pin2_sel = pin2_r[`PIN_SEL_HI:`PIN_SEL_LO];
  wire [2:0] pin2_drv = pin2_r[`PIN_DRV_HI:`PIN_DRV_LO];
  // Live lock detect replaces the external source at code 2, both locks ANDed at code 3
  wire       src_raw  = (pin2_sel > 5'h12) ? 1'b0 : PIN_SOURCES[pin2_sel];
  wire       src_bit  = (pin2_sel == `SEL_LOOP_B) ? lock_b :
                        (pin2_sel == `SEL_BOTH) ? (lock_b & LOOP_A_LOCK) :
                        src_raw;
  // Code 3 push-pull, 4 inverted, 6 open drain; others hold pin off
  wire       drv_pp   = (pin2_drv == 3'h3);
  wire       drv_inv  = (pin2_drv == 3'h4);
  wire       drv_od   = (pin2_drv == 3'h6);
  wire       pin_o    = drv_inv ? ~src_bit : (drv_od ? 1'b0 : src_bit);
  wire       pin_oe   = drv_pp | drv_inv | (drv_od & ~src_bit);
  wire       cal_go   = we_fbl & ~cal_r[`CAL_DIS_BIT];

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA            <= 32'h0000_0000;
      ANALOG_CTRL       <= '0;
      LOOP_B_LOCK       <= 1'b0;
      CAL_START         <= 1'b0;
      ALIGN_REQUEST     <= 1'b0;
      STATUS_PIN_TWO_O  <= 1'b0;
      STATUS_PIN_TWO_OE <= 1'b0;
    end else if (CE) begin
      HRDATA <= {24'h00_0000, a_read ? rd_sel : rd_data_r};
      ANALOG_CTRL.lock_window <= pump_r[`WND_HI:`WND_LO];
      ANALOG_CTRL.pump_gain <= pump_r[`GAIN_HI:`GAIN_LO];
      ANALOG_CTRL.pump_polarity <= pump_r[`POL_BIT];
      ANALOG_CTRL.pump_hiz <= pump_r[`HIZ_BIT];
      ANALOG_CTRL.align_request_enable <= cnt_hi_r[`ALIGN_EN_BIT];
      ANALOG_CTRL.filter_res_four_sel <= res_r[`RES4_HI:`RES4_LO];
      ANALOG_CTRL.filter_res_three_sel <= res_r[`RES3_HI:`RES3_LO];
      ANALOG_CTRL.filter_cap_four_sel <= cap_r[`CAP4_HI:`CAP4_LO];
      ANALOG_CTRL.filter_cap_three_sel <= cap_r[`CAP3_HI:`CAP3_LO];
      ANALOG_CTRL.status_pin_two_select <= pin2_sel;
      ANALOG_CTRL.status_pin_two_drive <= pin2_drv;
      ANALOG_CTRL.prescaler_off <= pwr_r[`PRE_OFF_BIT];
      ANALOG_CTRL.power_off <= pwr_r[`PWR_OFF_BIT];
      LOOP_B_LOCK <= lock_b;
      CAL_START <= cal_go;
      // Gate with the published enable, so the pin follows the register field two cycles later
      ALIGN_REQUEST <= ANALOG_CTRL.align_request_enable & ALIGN_PULSE;
      STATUS_PIN_TWO_O <= pin_o;
      STATUS_PIN_TWO_OE <= pin_oe;
    end
  end

  // Zero-wait slave: no stall, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

endmodule : loopb_regs

// ===== bench/ahb_host.sv
// Bus host model issuing single AHB-Lite word transfers
`timescale 1ns/1ps

module ahb_host (
  // Clock
  input  wire logic        clk,
  // Bus answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Bus request
  output logic             hsel,
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'h0;
    haddr  = 12'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  // ==========================================================
  // One transfer; waits on the answer, only the watchdog ends a hang
  task automatic xfer(input logic wr, input logic [8:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clk);
    hsel   <= 1'h1;
    haddr  <= {1'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'h1);
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata[7:0];
    hsel <= 1'h0;
  endtask : xfer
endmodule : ahb_host

// ===== bench/loopb_regs_properties.sv
// Port-level assertions for the loop-b register bank
`timescale 1ns/1ps
`include "loopb_regs_defs.svh"

module loopb_checker (
  // Clock and reset
  input wire logic                            CLK,
  input wire logic                            RESETN,
  // Bus request
  input wire logic                            HSEL,
  input wire logic [11:0]                     HADDR,
  input wire logic [1:0]                      HTRANS,
  input wire logic                            HWRITE,
  input wire logic                            HREADY,
  // Loop side
  input wire logic                            PD_EVENT,
  input wire logic                            PD_IN_WINDOW,
  input wire logic                            ALIGN_PULSE,
  input wire loopb_regs_pkg::analog_ctrl_type ANALOG_CTRL,
  input wire logic                            LOOP_B_LOCK,
  input wire logic                            CAL_START,
  input wire logic                            ALIGN_REQUEST,
  input wire logic                            STATUS_PIN_TWO_O,
  input wire logic                            STATUS_PIN_TWO_OE
);
  logic       cal_wr_r;
  logic [2:0] drv;

  assign drv = ANALOG_CTRL.status_pin_two_drive;

  // Remembers a write address phase aimed at the calibration strobe
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cal_wr_r <= 1'h0;
    end else begin
      cal_wr_r <= HSEL && HREADY && HTRANS[1] && HWRITE &&
                  (HADDR[11:2] == {1'h0, `IDX_FEEDBACK_LO});
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // ==========================================================
  // Properties
  property p_align;
    ALIGN_REQUEST == $past(ALIGN_PULSE && ANALOG_CTRL.align_request_enable);
  endproperty
  a_align: assert property (p_align)
    else $error("align request not enable and pulse");

  property p_lock_rise;
    $rose(LOOP_B_LOCK) |-> $past(PD_EVENT && PD_IN_WINDOW, 2) ||
                           $past(PD_EVENT && PD_IN_WINDOW, 3);
  endproperty
  a_lock_rise: assert property (p_lock_rise)
    else $error("lock rose without an in-window event");

  property p_lock_drop;
    PD_EVENT && !PD_IN_WINDOW |-> ##[1:3] !LOOP_B_LOCK;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock kept after out-of-window event");

  property p_power;
    (ANALOG_CTRL.power_off)[*4] |-> !LOOP_B_LOCK;
  endproperty
  a_power: assert property (p_power)
    else $error("lock shown while loop powered down");

  property p_open_drain;
    (drv == 3'h6)[*3] ##0 STATUS_PIN_TWO_OE |-> !STATUS_PIN_TWO_O;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin driven high");

  property p_reserved_drive;
    (!(drv inside {3'h3, 3'h4, 3'h6}))[*3] |-> !STATUS_PIN_TWO_OE;
  endproperty
  a_reserved_drive: assert property (p_reserved_drive)
    else $error("pin driven under reserved drive code");

  property p_logic_low;
    (drv == 3'h3 && ANALOG_CTRL.status_pin_two_select == 5'h0)[*3]
      |-> STATUS_PIN_TWO_OE && !STATUS_PIN_TWO_O;
  endproperty
  a_logic_low: assert property (p_logic_low)
    else $error("logic low source not driven low");

  property p_cal;
    CAL_START |-> $past(cal_wr_r, 1) || $past(cal_wr_r, 2) ||
                  $past(cal_wr_r, 3) || $past(cal_wr_r, 4);
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration start without strobe write");
endmodule : loopb_checker

bind loopb_regs loopb_checker u_chk (
  .CLK(CLK), .RESETN(RESETN), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY),
  .PD_EVENT(PD_EVENT), .PD_IN_WINDOW(PD_IN_WINDOW),
  .ALIGN_PULSE(ALIGN_PULSE), .ANALOG_CTRL(ANALOG_CTRL),
  .LOOP_B_LOCK(LOOP_B_LOCK), .CAL_START(CAL_START),
  .ALIGN_REQUEST(ALIGN_REQUEST), .STATUS_PIN_TWO_O(STATUS_PIN_TWO_O),
  .STATUS_PIN_TWO_OE(STATUS_PIN_TWO_OE)
);

// ===== bench/testbench.sv
// Self-checking bench for the loop-b register bank
`timescale 1ns/1ps

module testbench;
  logic        CLK, RESETN, HSEL, HWRITE, HREADYOUT, HRESP;
  logic        LOOP_A_LOCK, PD_EVENT, PD_IN_WINDOW, ALIGN_PULSE;
  logic        LOOP_B_LOCK, CAL_START, ALIGN_REQUEST;
  logic        STATUS_PIN_TWO_O, STATUS_PIN_TWO_OE;
  logic [11:0] HADDR;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic [31:0] HWDATA, HRDATA;
  logic [7:0]  rd_v;
  loopb_regs_pkg::input_status_type INPUT_STATUS;
  loopb_regs_pkg::analog_ctrl_type  ANALOG_CTRL, exp_ctrl;
  int          n_mismatch = 0;
  int          checks = 0;
  int          n_cal = 0;

  // Rows: index, reset value, value written, value read back
  localparam logic [32:0] ROWS [12] = '{
    {9'h169, 8'h59, 8'h47, 8'h47}, {9'h16a, 8'h20, 8'h40, 8'h40},
    {9'h16b, 8'h00, 8'h03, 8'h03}, {9'h16c, 8'h00, 8'h1c, 8'h1c},
    {9'h16d, 8'h00, 8'hd9, 8'hd9}, {9'h16e, 8'h16, 8'h93, 8'h93},
    {9'h171, 8'h0a, 8'haa, 8'haa}, {9'h172, 8'h00, 8'h02, 8'h02},
    {9'h173, 8'h00, 8'h40, 8'h40}, {9'h17c, 8'h00, 8'h15, 8'h15},
    {9'h17d, 8'h00, 8'h33, 8'h33}, {9'h170, 8'h00, 8'h55, 8'h00}};

  ahb_host host (
    .clk(CLK), .hready(HREADYOUT), .hrdata(HRDATA), .hsel(HSEL),
    .haddr(HADDR), .htrans(HTRANS), .hwrite(HWRITE), .hsize(HSIZE),
    .hwdata(HWDATA));

  loopb_regs dut (
    .CLK(CLK), .RESETN(RESETN), .CE(1'h1), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .LOOP_A_LOCK(LOOP_A_LOCK), .PD_EVENT(PD_EVENT),
    .PD_IN_WINDOW(PD_IN_WINDOW), .INPUT_STATUS(INPUT_STATUS),
    .ALIGN_PULSE(ALIGN_PULSE), .PIN_SOURCES(19'h0),
    .ANALOG_CTRL(ANALOG_CTRL), .LOOP_B_LOCK(LOOP_B_LOCK),
    .CAL_START(CAL_START), .ALIGN_REQUEST(ALIGN_REQUEST),
    .STATUS_PIN_TWO_O(STATUS_PIN_TWO_O),
    .STATUS_PIN_TWO_OE(STATUS_PIN_TWO_OE));

  // ==========================================================
  // Clock, pulser and calibration counter
  initial begin
    CLK = 1'h0;
    forever #25 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    ALIGN_PULSE <= ~ALIGN_PULSE;
    if (CAL_START === 1'h1) n_cal++;
  end

  // ==========================================================
  // Shared tasks
  task automatic cmp(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask : cmp

  task automatic wr(input logic [8:0] idx, input logic [7:0] d);
    logic [7:0] dummy;
    host.xfer(1'h1, idx, d, dummy);
  endtask : wr

  task automatic rd_cmp(input logic [8:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    host.xfer(1'h0, idx, 8'h0, d);
    cmp(64'(d), 64'(exp));
  endtask : rd_cmp

  // Phase detector events, spaced so lock settles before the next one
  task automatic pd(input logic win, input int n);
    repeat (n) begin
      PD_EVENT     <= 1'h1;
      PD_IN_WINDOW <= win;
      @(posedge CLK);
      PD_EVENT <= 1'h0;
      repeat (4) @(posedge CLK);
    end
  endtask : pd

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5000) @(posedge CLK);
    n_mismatch++;
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence
  initial begin
    RESETN       = 1'h0;
    LOOP_A_LOCK  = 1'h0;
    PD_EVENT     = 1'h0;
    PD_IN_WINDOW = 1'h0;
    ALIGN_PULSE  = 1'h0;
    INPUT_STATUS = '{tuning_dac: 10'h2a5, ref_selected: 3'h4};
    repeat (3) @(posedge CLK);
    RESETN      <= 1'h1;
    LOOP_A_LOCK <= 1'h1;
    repeat (4) @(posedge CLK);
    foreach (ROWS[i]) begin
      rd_cmp(ROWS[i][32:24], ROWS[i][23:16]);
    end
    foreach (ROWS[i]) begin
      wr(ROWS[i][32:24], ROWS[i][15:8]);
      rd_cmp(ROWS[i][32:24], ROWS[i][7:0]);
    end
    exp_ctrl = '{2'h2, 2'h0, 1'h1, 1'h1, 1'h1, 3'h3, 3'h4, 4'hd, 4'h9,
                 5'h12, 3'h3, 1'h1, 1'h0};
    cmp(64'(ANALOG_CTRL), 64'(exp_ctrl));
    // Logic-low source through every drive code
    for (int c = 0; c < 8; c++) begin
      wr(9'h16e, {5'h0, 3'(c)});
      repeat (3) @(posedge CLK);
      cmp(64'({STATUS_PIN_TWO_OE, STATUS_PIN_TWO_O}),
          64'({c inside {3, 4, 6}, c == 4}));
    end
    wr(9'h16e, 8'h16);
    wr(9'h184, 8'hff);
    host.xfer(1'h0, 9'h184, 8'h0, rd_v);
    cmp(64'(rd_v[7:3]), 64'h14);
    // Lock after exactly three in-window events
    pd(1'h1, 2);
    cmp(64'(LOOP_B_LOCK), 64'h0);
    pd(1'h1, 1);
    cmp(64'(LOOP_B_LOCK), 64'h1);
    rd_cmp(9'h183, 8'h02);
    wr(9'h183, 8'h01);
    pd(1'h0, 1);
    LOOP_A_LOCK <= 1'h0;
    rd_cmp(9'h183, 8'h01);
    wr(9'h183, 8'h00);
    rd_cmp(9'h183, 8'h00);
    rd_cmp(9'h182, 8'h04);
    pd(1'h1, 3);
    pd(1'h0, 1);
    rd_cmp(9'h183, 8'h04);
    wr(9'h183, 8'h01);
    rd_cmp(9'h183, 8'h01);
    wr(9'h183, 8'h00);
    rd_cmp(9'h183, 8'h00);
    // Strobe starts calibration only while it is enabled
    wr(9'h168, 8'h0c);
    repeat (6) @(posedge CLK);
    cmp(64'(n_cal), 64'h1);
    wr(9'h166, 8'h04);
    wr(9'h168, 8'h0c);
    repeat (6) @(posedge CLK);
    cmp(64'(n_cal), 64'h1);
    wr(9'h173, 8'h20);
    pd(1'h1, 3);
    cmp(64'(LOOP_B_LOCK), 64'h0);
    tally_and_finish();
  end
endmodule : testbench
